// ### rtl/ctrl_port_pkg.sv
// constants for the codec serial control port
package ctrl_port_pkg;
  localparam logic [6:0] TWI_DEV_ADDR    = 7'h1A;
  localparam logic [7:0] SPI24_DEV_ADDR  = 8'h10;
  localparam logic [6:0] SPI_ENABLE_REG  = 7'h49;
  localparam int         SPI_ENABLE_BIT  = 8;
  localparam int         SPI16_BITS      = 16;
  localparam int         SPI24_HDR_BITS  = 15;
  localparam int         DATA_BITS       = 9;
  localparam int         SYNC_STAGES     = 3;
  localparam logic       WIDE_SPI_RESET  = 1'b0;
endpackage

// ### rtl/pin_sync.sv
// three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_b,
  // pin in, filtered level out
  input  wire logic pin,
  input  wire logic reset_level,
  output logic      level
);
  logic [2:0] stage;

  // first stage only feeds the second
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      stage <= 3'b111;
    end else begin
      stage <= {stage[1:0], pin};
    end
  end

  // a change counts once stages two and three agree
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      level <= 1'b1;
    end else if (stage[1] == stage[2]) begin
      level <= stage[2];
    end
  end
endmodule // pin_sync
`default_nettype wire

// ### rtl/codec_control_port.sv
// serial control port: 16-bit spi, 24-bit spi and two-wire slave
// What this block does
// RQ1: 16-bit spi frame is 7 address bits then 9 data bits.
// RQ2: after reset, select pin high with wide enable clear means 16-bit spi.
// RQ3: 16-bit spi writes only; commit data on chip select rising.
// RQ4: host opens 24-bit frame with select low, sends fields, raises select.
// RQ5: 24-bit spi takes many 9-bit blocks at successive addresses.
// RQ6: writing one to bit 8 of register 49h enters 24-bit spi.
// RQ7: clearing that bit through 24-bit write leaves; select pin then chooses.
// RQ8: two-wire bytes go msb first; device is slave only.
// RQ9: start and stop conditions are detected.
// RQ10: stop returns two-wire logic to idle.
// RQ11: transmitter releases data after 8 bits; receiver acks in ninth.
// RQ12: two-wire address is 0011010 plus direction flag.
// RQ13: direction flag one means read, zero means write.
// RQ14: ack low on address match, line left high otherwise.
// RQ15: control byte holds address 6..0 and d8; data byte holds d7..d0.
// RQ16: write is address, control, data bytes, stop; each byte acked.
// RQ17: master reads via control write, repeated start, read address.
// RQ18: device acks headers and sends bytes while master acks.
// RQ19: read pointer advances per byte and wraps 7fh to 00h.
// RQ20: protocol chosen by select pin and wide enable bit.
// RQ21: 24-bit frame is 8-bit device address, 7-bit register, 9 data.
// RQ22: 24-bit device address is 10h; others ignored.
// RQ23: spi msb first; serial clock may pause and resume.
// RQ24: while chip select is high spi clocks are ignored, partial frames dropped.
`timescale 1ns/1ps
`default_nettype none
module codec_control_port (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_b,
  // pins
  input  wire logic       mode_pin,
  input  wire logic       chip_select_n,
  input  wire logic       serial_clock,
  input  wire logic       sdio_in,
  output logic            sdio_out,
  output logic            sdio_oe,
  // register file side
  output logic            reg_write,
  output logic [6:0]      reg_addr,
  output logic [8:0]      reg_wdata,
  input  wire logic [8:0] reg_rdata,
  // current protocol
  output logic            wide_spi_enable,
  output logic            twi_selected
);
  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic cs_n_s, sclk_s, sdio_s, mode_s;
  logic cs_n_d, sclk_d, sdio_d;

  pin_sync u_cs (.clock(clock), .rst_b(rst_b), .pin(chip_select_n), .reset_level(1'b1),
                 .level(cs_n_s));
  pin_sync u_sck (.clock(clock), .rst_b(rst_b), .pin(serial_clock), .reset_level(1'b1),
                  .level(sclk_s));
  pin_sync u_sda (.clock(clock), .rst_b(rst_b), .pin(sdio_in), .reset_level(1'b1),
                  .level(sdio_s));
  pin_sync u_mode (.clock(clock), .rst_b(rst_b), .pin(mode_pin), .reset_level(1'b1),
                   .level(mode_s));

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cs_n_d <= 1'b1;
      sclk_d <= 1'b1;
      sdio_d <= 1'b1;
    end else begin
      cs_n_d <= cs_n_s;
      sclk_d <= sclk_s;
      sdio_d <= sdio_s;
    end
  end

  logic sclk_rise, sclk_fall, cs_rise, start_cond, stop_cond;
  assign sclk_rise  = sclk_s & ~sclk_d;
  assign sclk_fall  = ~sclk_s & sclk_d;
  assign cs_rise    = cs_n_s & ~cs_n_d;
  assign start_cond = sclk_s & sclk_d & sdio_d & ~sdio_s;  // RQ9
  assign stop_cond  = sclk_s & sclk_d & ~sdio_d & sdio_s;  // RQ9

  // ************************************************************
  // protocol selection
  // ************************************************************
  logic spi16_mode, spi24_mode;
  assign spi24_mode   = wide_spi_enable;                // RQ20
  assign spi16_mode   = ~wide_spi_enable & mode_s;      // RQ2 RQ20
  assign twi_selected = ~wide_spi_enable & ~mode_s;     // RQ20

  // ************************************************************
  // spi shifter, shared by both spi widths
  // ************************************************************
  logic [23:0] spi_shift;
  logic [4:0]  spi_count;
  logic [6:0]  spi24_addr;
  logic        spi24_hdr_ok;
  logic        spi24_hdr_done;
  logic        spi24_write, spi16_write;

  // sampling on rising edges only, so a paused clock just waits
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      spi_shift <= 24'h00_0000;
      spi_count <= 5'h00;
    end else if (cs_n_s || twi_selected) begin
      spi_shift <= 24'h00_0000;  // RQ24
      spi_count <= 5'h00;
    end else if (sclk_rise) begin
      spi_shift <= {spi_shift[22:0], sdio_s};  // RQ23
      // restart the count after the 15-bit header and after each 9-bit data block
      if (spi24_mode && !spi24_hdr_done &&
          spi_count == 5'(ctrl_port_pkg::SPI24_HDR_BITS - 1)) begin
        spi_count <= 5'h00;
      end else if (spi24_mode && spi24_hdr_done &&
                   spi_count == 5'(ctrl_port_pkg::DATA_BITS - 1)) begin
        spi_count <= 5'h00;
      end else if (spi_count != 5'h1F) begin
        spi_count <= spi_count + 5'h01;
      end
    end
  end

  // 24-bit header capture and auto-increment address
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      spi24_hdr_done <= 1'b0;
      spi24_hdr_ok   <= 1'b0;
      spi24_addr     <= 7'h00;
    end else if (cs_n_s || !spi24_mode) begin
      spi24_hdr_done <= 1'b0;  // RQ24
      spi24_hdr_ok   <= 1'b0;
    end else if (sclk_rise && !spi24_hdr_done &&
                 spi_count == 5'(ctrl_port_pkg::SPI24_HDR_BITS - 1)) begin
      spi24_hdr_done <= 1'b1;  // RQ21
      spi24_hdr_ok   <= spi_shift[13:6] == ctrl_port_pkg::SPI24_DEV_ADDR;  // RQ22
      spi24_addr     <= {spi_shift[5:0], sdio_s};
    end else if (spi24_write) begin
      spi24_addr <= spi24_addr + 7'h01;  // RQ5
    end
  end

  assign spi24_write = spi24_mode && !cs_n_s && sclk_rise && spi24_hdr_done && spi24_hdr_ok &&
                       spi_count == 5'(ctrl_port_pkg::DATA_BITS - 1);  // RQ5
  assign spi16_write = spi16_mode && cs_rise &&
                       spi_count == 5'(ctrl_port_pkg::SPI16_BITS);  // RQ1 RQ3

  // ************************************************************
  // two-wire slave
  // ************************************************************
  typedef enum logic [5:0] {
    TW_IDLE = 6'b00_0001,
    TW_ADDR = 6'b00_0010,
    TW_CTRL = 6'b00_0100,
    TW_DATA = 6'b00_1000,
    TW_SEND = 6'b01_0000,
    TW_HOLD = 6'b10_0000
  } tw_state_e;

  tw_state_e   tw_state;
  logic [7:0]  tw_shift;
  logic [3:0]  tw_bit;
  logic        tw_ack_slot;
  logic        tw_drive_low;
  logic [6:0]  tw_ptr;
  logic        tw_d8;
  logic [7:0]  tw_tx;
  logic        tw_write;
  logic        master_nak;
  logic [7:0]  rx_byte;
  assign rx_byte = {tw_shift[6:0], sdio_s};  // RQ8

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tw_state    <= TW_IDLE;
      tw_shift    <= 8'h00;
      tw_bit      <= 4'h0;
      tw_ack_slot <= 1'b0;
      tw_ptr      <= 7'h00;
      tw_d8       <= 1'b0;
      master_nak  <= 1'b0;
    end else if (!twi_selected || stop_cond) begin
      tw_state    <= TW_IDLE;  // RQ10
      tw_bit      <= 4'h0;
      tw_ack_slot <= 1'b0;
    end else if (start_cond) begin
      tw_state    <= TW_ADDR;  // RQ9 RQ17
      tw_bit      <= 4'h0;
      tw_ack_slot <= 1'b0;
    end else if (sclk_rise && !tw_ack_slot && tw_state != TW_IDLE && tw_state != TW_HOLD) begin
      tw_shift <= rx_byte;
      tw_bit   <= tw_bit + 4'h1;
    end else if (sclk_rise && tw_ack_slot && tw_state == TW_SEND) begin
      master_nak <= sdio_s;  // RQ18
    end else if (sclk_fall && tw_bit == 4'h8) begin
      tw_bit      <= 4'h0;
      tw_ack_slot <= 1'b1;  // RQ11
      unique case (tw_state)
        TW_ADDR: begin
          if (tw_shift[7:1] != ctrl_port_pkg::TWI_DEV_ADDR) begin
            tw_state <= TW_HOLD;  // RQ12
          end else if (tw_shift[0]) begin
            tw_state <= TW_SEND;  // RQ13
          end else begin
            tw_state <= TW_CTRL;
          end
        end
        TW_CTRL: begin
          tw_ptr   <= tw_shift[7:1];  // RQ15
          tw_d8    <= tw_shift[0];
          tw_state <= TW_DATA;
        end
        TW_DATA: begin
          tw_ptr <= tw_ptr + 7'h01;
        end
        TW_SEND: begin
          tw_ptr <= tw_ptr + 7'h01;  // RQ19
        end
        default: begin
          tw_state <= TW_HOLD;
        end
      endcase
    end else if (sclk_fall && tw_ack_slot) begin
      tw_ack_slot <= 1'b0;
      if (tw_state == TW_SEND && master_nak) begin
        tw_state <= TW_HOLD;  // RQ18
      end
    end
  end

  assign tw_write = twi_selected && tw_state == TW_DATA && sclk_fall && tw_bit == 4'h8 &&
                    !tw_ack_slot;  // RQ16

  // transmit byte loaded at the start of every send byte
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tw_tx <= 8'hFF;
    end else if (tw_state == TW_SEND && tw_bit == 4'h0 && !tw_ack_slot && sclk_rise == 1'b0 &&
                 sclk_s == 1'b0) begin
      tw_tx <= reg_rdata[7:0];
    end else if (tw_state == TW_SEND && sclk_fall && !tw_ack_slot) begin
      tw_tx <= {tw_tx[6:0], 1'b1};  // RQ8
    end
  end

  // data line driver; releasing keeps the line high for nak
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tw_drive_low <= 1'b0;
    end else if (!twi_selected || stop_cond || start_cond) begin
      tw_drive_low <= 1'b0;
    end else if (sclk_fall && tw_bit == 4'h8 && !tw_ack_slot) begin
      tw_drive_low <= tw_state != TW_SEND &&
                      (tw_state != TW_ADDR ||
                       tw_shift[7:1] == ctrl_port_pkg::TWI_DEV_ADDR);  // RQ14 RQ16 RQ18
    end else if (sclk_fall && tw_ack_slot) begin
      tw_drive_low <= 1'b0;  // RQ11
    end else if (tw_state == TW_SEND && !tw_ack_slot && !sclk_s) begin
      tw_drive_low <= ~tw_tx[7];
    end
  end

  assign sdio_out = 1'b0;
  assign sdio_oe  = tw_drive_low;

  // ************************************************************
  // register write port and wide spi enable
  // ************************************************************
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reg_write <= 1'b0;
      reg_addr  <= 7'h00;
      reg_wdata <= 9'h000;
    end else begin
      reg_write <= spi16_write || spi24_write || tw_write;
      if (spi16_write) begin
        reg_addr  <= spi_shift[15:9];  // RQ1 RQ3
        reg_wdata <= spi_shift[8:0];
      end else if (spi24_write) begin
        reg_addr  <= spi24_addr;
        reg_wdata <= {spi_shift[7:0], sdio_s};
      end else if (tw_write) begin
        reg_addr  <= tw_ptr;
        reg_wdata <= {tw_d8, tw_shift};  // RQ15
      end else if (twi_selected) begin
        reg_addr  <= tw_ptr;  // read pointer
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wide_spi_enable <= ctrl_port_pkg::WIDE_SPI_RESET;
    end else if (reg_write && reg_addr == ctrl_port_pkg::SPI_ENABLE_REG) begin
      wide_spi_enable <= reg_wdata[ctrl_port_pkg::SPI_ENABLE_BIT];  // RQ6 RQ7
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  property p_spi16_commit;
    @(posedge clock) disable iff (!rst_b)
      spi16_write |=> reg_write && reg_wdata == $past(spi_shift[8:0]);
  endproperty
  a_spi16_commit: assert property (p_spi16_commit) else $error("spi16 commit lost"); // RQ3

  property p_spi24_inc;
    @(posedge clock) disable iff (!rst_b)
      spi24_write |=> spi24_addr == $past(spi24_addr) + 7'h01;
  endproperty
  a_spi24_inc: assert property (p_spi24_inc) else $error("spi24 address stuck"); // RQ5

  property p_enable_set;
    @(posedge clock) disable iff (!rst_b)
      reg_write && reg_addr == ctrl_port_pkg::SPI_ENABLE_REG
      |=> wide_spi_enable == $past(reg_wdata[8]);
  endproperty
  a_enable_set: assert property (p_enable_set) else $error("wide enable not updated"); // RQ6

  property p_cs_idle;
    @(posedge clock) disable iff (!rst_b)
      cs_n_s && cs_n_d && !twi_selected |=> !reg_write [*2];
  endproperty
  a_cs_idle: assert property (p_cs_idle) else $error("write while select high"); // RQ24

  property p_stop_idle;
    @(posedge clock) disable iff (!rst_b)
      stop_cond && twi_selected |=> tw_state == TW_IDLE && !sdio_oe;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop not honoured"); // RQ10

  property p_nak_mismatch;
    @(posedge clock) disable iff (!rst_b)
      tw_state == TW_HOLD |-> !sdio_oe;
  endproperty
  a_nak_mismatch: assert property (p_nak_mismatch) else $error("drove line unaddressed"); // RQ14

  property p_mode_sel;
    @(posedge clock) disable iff (!rst_b)
      $rose(wide_spi_enable) |-> !twi_selected && !spi16_mode;
  endproperty
  a_mode_sel: assert property (p_mode_sel) else $error("protocol select wrong"); // RQ20

  property p_ptr_wrap;
    @(posedge clock) disable iff (!rst_b)
      tw_state == TW_SEND && sclk_fall && tw_bit == 4'h8 && !tw_ack_slot && tw_ptr == 7'h7F
      |=> tw_ptr == 7'h00;
  endproperty
  a_ptr_wrap: assert property (p_ptr_wrap) else $error("pointer did not wrap"); // RQ19
endmodule // codec_control_port
`default_nettype wire

// ### verification/host_master_model.sv
// host master model driving the control port pins
`timescale 1ns/1ps
`default_nettype none
module host_master_model (
  // pacing clock
  input  wire logic clock,
  // device side of the data line
  input  wire logic sdio_out,
  input  wire logic sdio_oe,
  // pins toward the device
  output var logic  serial_clock,
  output var logic  chip_select_n,
  output logic      sdio_in
);
  // ****************
  // line and pacing
  // ****************
  logic drive_low;
  // pull-up: a released line reads high, never the last value
  assign sdio_in = (drive_low || (sdio_oe && !sdio_out)) ? 1'b0 : 1'b1;
  initial begin
    serial_clock = 1'b0;
    chip_select_n = 1'b1;
    drive_low = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge clock);
  endtask
  // spi clock stands low outside frames
  task automatic spi(input logic [47:0] bits, input int n, input int pause_at);
    chip_select_n = 1'b0;
    hold(2);
    for (int i = 47; i > 47 - n; i--) begin
      drive_low = ~bits[i];
      hold(4);
      serial_clock = 1'b1;
      hold(4);
      serial_clock = 1'b0;
      if (i == pause_at) hold(40);
    end
    hold(2);
    chip_select_n = 1'b1;
    drive_low = 1'b0;
    hold(12);
  endtask
  // two-wire phases of 8 clocks; data moves 2 clocks after scl falls
  task automatic start();
    drive_low = 1'b0;
    hold(8);
    serial_clock = 1'b1;
    hold(8);
    drive_low = 1'b1;
    hold(8);
    serial_clock = 1'b0;
    hold(8);
  endtask
  task automatic stop();
    drive_low = 1'b1;
    hold(8);
    serial_clock = 1'b1;
    hold(8);
    drive_low = 1'b0;
    hold(16);
  endtask
  task automatic clk_pulse();
    hold(6);
    serial_clock = 1'b1;
    hold(8);
    serial_clock = 1'b0;
    hold(2);
  endtask
  task automatic put(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      drive_low = ~b[i];
      clk_pulse();
    end
    drive_low = 1'b0;
    hold(6);
    serial_clock = 1'b1;
    hold(4);
    ack = sdio_in;
    hold(4);
    serial_clock = 1'b0;
    hold(2);
  endtask
  task automatic get(input logic ack_low, output logic [7:0] b);
    drive_low = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      hold(6);
      serial_clock = 1'b1;
      hold(4);
      b[i] = sdio_in;
      hold(4);
      serial_clock = 1'b0;
      hold(2);
    end
    // ack level stands until the next phase moves the line
    drive_low = ack_low;
    clk_pulse();
  endtask
endmodule // host_master_model
`default_nettype wire

// ### verification/codec_control_port_tb.sv
// self-checking bench for the serial control port
`timescale 1ns/1ps
`default_nettype none
`define CHECK(name, exp, got) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
      n_errors++; \
      $display("ERROR %s expected %0h seen %0h", name, exp, got); \
    end \
  end
module codec_control_port_tb;
  // ****************
  // pins and monitor
  // ****************
  logic       clock, rst_b, mode_pin, chip_select_n, serial_clock, sdio_in;
  logic       sdio_out, sdio_oe, reg_write, wide_spi_enable, twi_selected;
  logic [6:0] reg_addr;
  logic [8:0] reg_wdata, reg_rdata;
  logic [6:0] wq_a[$];
  logic [8:0] wq_d[$];
  int         n_errors = 0;
  int         n_compared = 0;
  // low byte of read data is one then the pointer, so order shows
  assign reg_rdata = {2'b01, reg_addr};
  codec_control_port DUT (.clock(clock), .rst_b(rst_b), .mode_pin(mode_pin),
    .chip_select_n(chip_select_n), .serial_clock(serial_clock), .sdio_in(sdio_in),
    .sdio_out(sdio_out), .sdio_oe(sdio_oe), .reg_write(reg_write), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .wide_spi_enable(wide_spi_enable),
    .twi_selected(twi_selected));
  host_master_model host (.clock(clock), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .serial_clock(serial_clock), .chip_select_n(chip_select_n), .sdio_in(sdio_in));
  initial clock = 1'b0;
  always #12.5 clock = ~clock;
  // sampled mid-cycle, where the registered write port has settled
  always @(negedge clock) begin
    if (reg_write === 1'b1) begin
      wq_a.push_back(reg_addr);
      wq_d.push_back(reg_wdata);
    end
  end
  task automatic exp_write(input logic [6:0] a, input logic [8:0] d);
    logic [6:0] ga;
    logic [8:0] gd;
    ga = 'x;
    gd = 'x;
    if (wq_a.size() != 0) begin
      ga = wq_a.pop_front();
      gd = wq_d.pop_front();
    end
    `CHECK("write addr", a, ga);
    `CHECK("write data", d, gd);
  endtask
  task automatic exp_none();
    `CHECK("spurious writes", 0, wq_a.size());
    wq_a.delete();
    wq_d.delete();
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_spi16();
    `CHECK("reset wide", 1'b0, wide_spi_enable);
    `CHECK("reset twi", 1'b0, twi_selected);
    host.spi({7'h05, 9'h1A5, 32'h0}, 16, 40);
    exp_write(7'h05, 9'h1A5);
    host.spi({7'h06, 9'h0FF, 32'h0}, 10, -1);
    exp_none();
  endtask
  task automatic t_spi24();
    host.spi({7'h49, 9'h100, 32'h0}, 16, -1);
    exp_write(7'h49, 9'h100);
    `CHECK("wide on", 1'b1, wide_spi_enable);
    host.spi({8'h10, 7'h7E, 9'h0C3, 9'h155, 15'h0}, 33, -1);
    exp_write(7'h7E, 9'h0C3);
    exp_write(7'h7F, 9'h155);
    host.spi({8'h11, 7'h20, 9'h0AA, 24'h0}, 24, -1);
    exp_none();
    mode_pin = 1'b0;
    host.spi({8'h10, 7'h49, 9'h000, 24'h0}, 24, -1);
    exp_write(7'h49, 9'h000);
    `CHECK("wide off", 1'b0, wide_spi_enable);
    `CHECK("twi after exit", 1'b1, twi_selected);
  endtask
  task automatic t_twi_write();
    logic a0, a1, a2;
    host.start();
    host.put(8'h34, a0);
    host.put({7'h12, 1'b1}, a1);
    host.put(8'h5A, a2);
    host.stop();
    `CHECK("addr ack", 1'b0, a0);
    `CHECK("ctrl ack", 1'b0, a1);
    `CHECK("data ack", 1'b0, a2);
    exp_write(7'h12, 9'h15A);
    host.start();
    host.put(8'h36, a0);
    host.stop();
    `CHECK("foreign ack", 1'b1, a0);
    exp_none();
  endtask
  task automatic t_twi_read();
    logic       a0, a1, a2;
    logic [7:0] b0, b1;
    host.start();
    host.put(8'h34, a0);
    host.put({7'h7F, 1'b0}, a1);
    host.start();
    host.put(8'h35, a2);
    host.get(1'b1, b0);
    host.get(1'b0, b1);
    host.stop();
    `CHECK("hdr ack", 3'b000, {a0, a1, a2});
    `CHECK("read byte 0", 8'hFF, b0);
    `CHECK("read byte 1", 8'h80, b1);
    exp_none();
  endtask
  // ****************
  // run control
  // ****************
  task automatic report_and_stop();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clock);
    n_errors++;
    report_and_stop();
  end
  initial begin
    rst_b = 1'b0;
    mode_pin = 1'b1;
    repeat (4) @(negedge clock);
    rst_b = 1'b1;
    repeat (8) @(negedge clock);
    t_spi16();
    t_spi24();
    t_twi_write();
    t_twi_read();
    report_and_stop();
  end
endmodule // codec_control_port_tb
`default_nettype wire
